// ===== ghbi_count_mem.sv
// Purpose: last-seen count per remote writer slot
// Assumes: one write and one read port on sys_clk
// Notes: no reset; the owner keeps per-slot valid bits
`timescale 1ns/1ps
`default_nettype none
module ghbi_count_mem
    import ghbi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [CNT_W-1:0] wrData,
    input wire logic rdEn,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [CNT_W-1:0] rdData
);
    // storage array, small enough for registers or lutram
    logic [CNT_W-1:0] mem [SLOTS];

    // write port
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read so the owner sees data one edge later
    always_ff @(posedge sys_clk) begin
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule
`default_nettype wire

// ===== ghbi_interp.sv
// Purpose: reader-side interpreter for gap, heartbeat, heartbeat-frag
// Assumes: fields parsed upstream; prefixes held by the receiver outside
// Notes: one submessage per two cycles; results are registered pulses
// What this block does
// - gap range start to base minus one
// - gap bitmap entries also irrelevant
// - gap writer guid from source prefix
// - gap reader guid from destination prefix
// - reject gap with nonpositive start
// - reject bad heartbeat sequence numbers
// - reject submessage with short length
// - final clear forces acknack reply, except for duplicates
// - final set needs no reply
// - otherwise reply only when changes missing
// - liveliness flag renews writer lease, except for duplicates
// - heartbeat guids from both prefixes
// - unknown reader id means all readers
// - receiver prefix state left untouched
// - fragments one to last available
// - reject frag with nonpositive numbers
`timescale 1ns/1ps
`default_nettype none
module ghbi_interp
    import ghbi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [7:0] inKind,
    input wire logic [7:0] inFlags,
    input wire logic [15:0] inLength,
    input wire logic [31:0] inReaderId,
    input wire logic [31:0] inWriterId,
    input wire logic [63:0] inSeqA,
    input wire logic [63:0] inSeqB,
    input wire logic [8:0] inNumBits,
    input wire logic [MAP_BITS-1:0] inBitmap,
    input wire logic [31:0] inLastFrag,
    input wire logic [CNT_W-1:0] inCount,
    input wire logic [SLOT_W-1:0] inSlot,
    input wire logic inMissing,
    input wire logic [95:0] srcPrefix,
    input wire logic [95:0] dstPrefix,
    output logic evtDone,
    output logic evtError,
    output logic evtDup,
    output logic [7:0] evtKind,
    output logic [127:0] writerGuid,
    output logic [127:0] readerGuid,
    output logic allReaders,
    output logic [63:0] gapFirst,
    output logic [63:0] gapLast,
    output logic gapRangeValid,
    output logic [63:0] gapBase,
    output logic [MAP_BITS-1:0] gapBitmap,
    output logic [63:0] hbFirst,
    output logic [63:0] hbLast,
    output logic ackNackReq,
    output logic leaseRenew,
    output logic [63:0] fragSn,
    output logic [31:0] fragLow,
    output logic [31:0] fragHigh
);
    // strictly positive sequence or fragment number
    function automatic logic isPos64(input logic [63:0] v);
        isPos64 = !v[63] && (v != 64'h0000000000000000);
    endfunction
    function automatic logic isPos32(input logic [31:0] v);
        isPos32 = !v[31] && (v != 32'h00000000);
    endfunction

    ghbi_state_t state; // controller state
    logic take; // submessage accepted this edge
    logic [7:0] sKind; // captured fields
    logic [7:0] sFlags;
    logic [15:0] sLength;
    logic [31:0] sReaderId;
    logic [31:0] sWriterId;
    logic [63:0] sSeqA;
    logic [63:0] sSeqB;
    logic [8:0] sNumBits;
    logic [MAP_BITS-1:0] sBitmap;
    logic [31:0] sLastFrag;
    logic [CNT_W-1:0] sCount;
    logic [ADDR_W-1:0] sAddr;
    logic sMissing;
    logic [SLOTS-1:0] slotSeen; // count slot holds a real value
    logic [CNT_W-1:0] lastCount; // stored count from the table
    logic isGap, isHb, isHbf; // kind decode of the captured message
    logic validMsg; // passes all validity checks
    logic dupMsg; // unchanged count, duplicate copy
    logic [MAP_BITS-1:0] mapMask; // bits beyond numBits are ignored

    assign take = inValid && inReady;
    assign inReady = (state == ST_IDLE);
    assign isGap = (sKind == KIND_GAP);
    assign isHb = (sKind == KIND_HEARTBEAT);
    assign isHbf = (sKind == KIND_HB_FRAG);

    // masks the bitmap down to its declared length
    generate
        for (genvar i = 0; i < MAP_BITS; i++) begin : g_mask
            assign mapMask[i] = (9'(i) < sNumBits);
        end
    endgenerate

    // validity per kind; unknown kinds count as invalid
    always_comb begin
        validMsg = 1'b0;
        unique case (1'b1)
            isGap: begin
                validMsg = isPos64(sSeqA)
                    && isPos64(sSeqB) && (sNumBits <= MAP_BITS_MAX)
                    && (sLength >= LEN_GAP_MIN + ((sNumBits != 9'h000) ? LEN_GAP_MAP
                        : 16'h0000));
            end
            isHb: begin
                validMsg = isPos64(sSeqA) && isPos64(sSeqB)
                    && ($signed(sSeqB) >= $signed(sSeqA))
                    && (sLength >= LEN_HB_MIN);
            end
            isHbf: begin
                validMsg = isPos64(sSeqA) && isPos32(sLastFrag)
                    && (sLength >= LEN_HBF_MIN);
            end
            default: validMsg = 1'b0;
        endcase
    end

    // duplicates over redundant paths repeat the sender's count
    assign dupMsg = (isHb || isHbf) && slotSeen[sAddr] && (lastCount == sCount);

    // controller: accept, then evaluate for one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: if (take) state <= ST_EVAL;
                ST_EVAL: state <= ST_IDLE;
            endcase
        end
    end

    // capture the submessage; prefixes are not captured here, only read into the guids at evaluation
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sKind <= 8'h00;
            sFlags <= 8'h00;
            sLength <= 16'h0000;
            sReaderId <= 32'h00000000;
            sWriterId <= 32'h00000000;
            sSeqA <= 64'h0000000000000000;
            sSeqB <= 64'h0000000000000000;
            sNumBits <= 9'h000;
            sBitmap <= 32'h00000000;
            sLastFrag <= 32'h00000000;
            sCount <= 32'h00000000;
            sAddr <= 5'h00;
            sMissing <= 1'b0;
        end else if (take) begin
            sKind <= inKind;
            sFlags <= inFlags;
            sLength <= inLength;
            sReaderId <= inReaderId;
            sWriterId <= inWriterId;
            sSeqA <= inSeqA;
            sSeqB <= inSeqB;
            sNumBits <= inNumBits;
            sBitmap <= inBitmap;
            sLastFrag <= inLastFrag;
            sCount <= inCount;
            sAddr <= {inKind == KIND_HB_FRAG, inSlot};
            sMissing <= inMissing;
        end
    end

    // a slot becomes valid on its first accepted heartbeat or heartbeat-frag
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slotSeen <= '0;
        end else if (state == ST_EVAL && validMsg && (isHb || isHbf)) begin
            slotSeen[sAddr] <= 1'b1;
        end
    end

    // count table; invalid messages never touch it
    ghbi_count_mem u_cnt (
        .sys_clk(sys_clk),
        .wrEn(state == ST_EVAL && validMsg && (isHb || isHbf)),
        .wrAddr(sAddr),
        .wrData(sCount),
        .rdEn(take),
        .rdAddr({inKind == KIND_HB_FRAG, inSlot}),
        .rdData(lastCount)
    );

    // status pulses, one cycle after evaluation
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evtDone <= 1'b0;
            evtError <= 1'b0;
            evtDup <= 1'b0;
            ackNackReq <= 1'b0;
            leaseRenew <= 1'b0;
        end else begin
            evtDone <= (state == ST_EVAL) && validMsg;
            evtError <= (state == ST_EVAL) && !validMsg;
            evtDup <= (state == ST_EVAL) && validMsg && dupMsg;
            // for a new heartbeat, final clear forces a reply; else only when something is missing
            ackNackReq <= (state == ST_EVAL) && validMsg && isHb && !dupMsg
                && (!sFlags[FLAG_FINAL] || sMissing);
            leaseRenew <= (state == ST_EVAL) && validMsg && isHb && !dupMsg
                && sFlags[FLAG_LIVELY];
        end
    end

    // result fields change only for valid messages, so invalid ones leave no trace
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evtKind <= 8'h00;
            writerGuid <= '0;
            readerGuid <= '0;
            allReaders <= 1'b0;
        end else if (state == ST_EVAL && validMsg) begin
            evtKind <= sKind;
            writerGuid <= {srcPrefix, sWriterId};
            readerGuid <= {dstPrefix, sReaderId};
            allReaders <= (sReaderId == ENTITY_UNKNOWN);
        end
    end

    // gap outputs: contiguous range plus bitmap relative to base
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gapFirst <= '0;
            gapLast <= '0;
            gapRangeValid <= 1'b0;
            gapBase <= '0;
            gapBitmap <= '0;
        end else if (state == ST_EVAL && validMsg && isGap) begin
            gapFirst <= sSeqA;
            gapLast <= sSeqB - SEQ_ONE;
            // an empty range when base does not exceed start
            gapRangeValid <= ($signed(sSeqB) > $signed(sSeqA));
            gapBase <= sSeqB;
            gapBitmap <= sBitmap & mapMask;
        end
    end

    // heartbeat and fragment availability
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hbFirst <= '0;
            hbLast <= '0;
            fragSn <= '0;
            fragLow <= '0;
            fragHigh <= '0;
        end else if (state == ST_EVAL && validMsg && !dupMsg) begin
            if (isHb) begin
                hbFirst <= sSeqA;
                hbLast <= sSeqB;
            end
            if (isHbf) begin
                fragSn <= sSeqA;
                fragLow <= FRAG_FIRST;
                fragHigh <= sLastFrag;
            end
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_HB_BAD_ORDER: assert property (
        (state == ST_EVAL && isHb && $signed(sSeqB) < $signed(sSeqA)) |=> evtError && !evtDone)
        else $error("heartbeat with last below first not rejected");
    AST_GAP_START: assert property (
        (state == ST_EVAL && isGap && !isPos64(sSeqA)) |=> evtError && !ackNackReq)
        else $error("gap with nonpositive start not rejected");
    AST_SHORT_LEN: assert property (
        (state == ST_EVAL && isHbf && sLength < LEN_HBF_MIN) |=> evtError)
        else $error("short heartbeat-frag accepted");
    AST_FINAL_CLEAR: assert property (
        (state == ST_EVAL && validMsg && isHb && !dupMsg && !sFlags[FLAG_FINAL])
        |=> ackNackReq)
        else $error("mandatory acknack missing");
    AST_NO_SPURIOUS_ACK: assert property (
        (state == ST_EVAL && sFlags[FLAG_FINAL] && !sMissing) |=> !ackNackReq)
        else $error("acknack without missing change");
    AST_LEASE: assert property (
        leaseRenew |-> $past(sFlags[FLAG_LIVELY]) && evtDone && evtKind == KIND_HEARTBEAT)
        else $error("lease renewed without liveliness flag");
    AST_GAP_RANGE: assert property (
        (evtDone && evtKind == KIND_GAP) |-> gapLast == gapBase - SEQ_ONE)
        else $error("gap range end not base minus one");
    AST_GUID: assert property (
        evtDone |-> writerGuid == {$past(srcPrefix), $past(sWriterId)})
        else $error("writer guid mismatch");
    AST_FRAG: assert property (
        (evtDone && evtKind == KIND_HB_FRAG && !evtDup) |-> fragLow == FRAG_FIRST
        && fragHigh == $past(sLastFrag))
        else $error("fragment range wrong");
    AST_INVALID_QUIET: assert property (
        evtError |-> !ackNackReq && !leaseRenew && $stable(writerGuid))
        else $error("invalid submessage had an effect");
    AST_SPACING: assert property (
        take |=> !inReady ##1 (evtDone || evtError))
        else $error("result not two cycles after take");

    COV_GAP: cover property (evtDone && evtKind == KIND_GAP && gapRangeValid);
    COV_HB_ACK: cover property (ackNackReq && leaseRenew);
    COV_DUP: cover property (evtDup && evtKind == KIND_HEARTBEAT);
    COV_ERR: cover property (evtError);
endmodule
`default_nettype wire

// ===== ghbi_pkg.sv
// Purpose: shared constants and types of the gap/heartbeat interpreter
// Assumes: submessage fields arrive already parsed and byte-swapped
// Notes: lengths are in bytes of submessage body, header excluded
package ghbi_pkg;
    // submessage kind codes on the wire
    localparam logic [7:0] KIND_GAP = 8'h08;
    localparam logic [7:0] KIND_HEARTBEAT = 8'h07;
    localparam logic [7:0] KIND_HB_FRAG = 8'h13;
    // header flag positions
    localparam int FLAG_FINAL = 1;
    localparam int FLAG_LIVELY = 2;
    // minimum body lengths in bytes
    localparam logic [15:0] LEN_GAP_MIN = 16'h001C;
    localparam logic [15:0] LEN_GAP_MAP = 16'h0004;
    localparam logic [15:0] LEN_HB_MIN = 16'h001C;
    localparam logic [15:0] LEN_HBF_MIN = 16'h0018;
    // gap bitmap capacity, one word
    localparam int MAP_BITS = 32;
    localparam logic [8:0] MAP_BITS_MAX = 9'h020;
    // unknown entity wildcard
    localparam logic [31:0] ENTITY_UNKNOWN = 32'h00000000;
    // first fragment number
    localparam logic [31:0] FRAG_FIRST = 32'h00000001;
    localparam logic [63:0] SEQ_ONE = 64'h0000000000000001;
    // duplicate table geometry: one slot per writer and kind
    localparam int SLOT_W = 4;
    localparam int ADDR_W = SLOT_W + 1;
    localparam int SLOTS = 1 << ADDR_W;
    localparam int CNT_W = 32;
    // controller states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EVAL = 2'b10
    } ghbi_state_t;
endpackage

// ===== ghbi_writer_model.sv
// Purpose: remote writer model feeding parsed submessages to the interpreter
// Assumes: a request is taken at an edge where inValid and inReady are both high
// Notes: counts advance per new heartbeat; a resend repeats the last count
`timescale 1ns/1ps
`default_nettype none
module ghbi_writer_model
    import ghbi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic inReady,
    output logic inValid,
    output logic [7:0] inKind,
    output logic [7:0] inFlags,
    output logic [15:0] inLength,
    output logic [31:0] inReaderId,
    output logic [31:0] inWriterId,
    output logic [63:0] inSeqA,
    output logic [63:0] inSeqB,
    output logic [8:0] inNumBits,
    output logic [MAP_BITS-1:0] inBitmap,
    output logic [31:0] inLastFrag,
    output logic [CNT_W-1:0] inCount,
    output logic [SLOT_W-1:0] inSlot,
    output logic timedOut
);
    logic [CNT_W-1:0] hbCnt = '0; // last heartbeat count sent
    logic [CNT_W-1:0] hbfCnt = '0; // last frag heartbeat count sent

    // idle at time zero, nothing offered
    initial begin
        inValid = 1'b0;
        timedOut = 1'b0;
        {inKind, inFlags, inLength, inReaderId, inWriterId, inSeqA, inSeqB} = '0;
        {inNumBits, inBitmap, inLastFrag, inCount, inSlot} = '0;
    end

    // one submessage; held until the take edge, then fields scrambled so that
    // a stale value is never mistaken for a live one
    task automatic send(input logic [7:0] k, input logic [7:0] f, input logic [15:0] len,
        input logic [31:0] rid, input logic [31:0] wid, input logic [63:0] a,
        input logic [63:0] b, input logic [8:0] nb, input logic [31:0] x,
        input logic again);
        int n;
        if (!again && k == KIND_HEARTBEAT) hbCnt = hbCnt + 1;
        if (!again && k == KIND_HB_FRAG) hbfCnt = hbfCnt + 1;
        @(posedge sys_clk);
        inValid <= 1'b1;
        {inKind, inFlags, inLength, inReaderId, inWriterId} <= {k, f, len, rid, wid};
        {inSeqA, inSeqB, inNumBits, inBitmap, inLastFrag} <= {a, b, nb, x, x};
        inCount <= (k == KIND_HB_FRAG) ? hbfCnt : hbCnt;
        inSlot <= wid[SLOT_W-1:0];
        n = 0;
        // bounded wait for the take
        do begin
            @(posedge sys_clk);
            n++;
        end while (inReady !== 1'b1 && n < 20);
        timedOut <= (inReady !== 1'b1);
        inValid <= 1'b0;
        {inSeqA, inSeqB, inBitmap, inLastFrag} <= ~{a, b, x, x};
        {inReaderId, inWriterId, inLength} <= ~{rid, wid, len};
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the gap/heartbeat interpreter
// Assumes: answer pulses appear exactly one edge after the take edge
// Notes: prefixes are held constant; the interpreter only reads them
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ghbi_pkg::*;
;
    localparam logic [63:0] NEG = 64'hFFFF_FFFF_FFFF_FFFF; // minus one
    logic sys_clk = 1'b0; // 50 MHz
    logic rst_n = 1'b0; // async, active low
    logic inMissing = 1'b0; // reader lacks an announced change
    logic [95:0] srcPrefix = 96'hA1B2_C3D4_E5F6_0718_293A_4B5C;
    logic [95:0] dstPrefix = 96'h5C4B_3A29_1807_F6E5_D4C3_B2A1;
    logic [8:0] nBits = 9'h004; // bitmap length used for gaps
    logic resend = 1'b0; // repeat the previous count
    logic [7:0] expKind = 8'h00; // kind of the last submessage that should have been accepted
    logic inValid, inReady, stuck;
    logic [7:0] inKind, inFlags, evtKind;
    logic [15:0] inLength;
    logic [31:0] inReaderId, inWriterId, inLastFrag, inBitmap, gapBitmap, fragLow, fragHigh;
    logic [63:0] inSeqA, inSeqB, gapFirst, gapLast, gapBase, hbFirst, hbLast, fragSn;
    logic [8:0] inNumBits;
    logic [CNT_W-1:0] inCount;
    logic [SLOT_W-1:0] inSlot;
    logic evtDone, evtError, evtDup, allReaders, gapRangeValid, ackNackReq, leaseRenew;
    logic [127:0] writerGuid, readerGuid;
    int miscompares = 0;
    int n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    ghbi_writer_model u_ghbi_writer_model (.sys_clk, .inReady, .inValid, .inKind, .inFlags,
        .inLength, .inReaderId, .inWriterId, .inSeqA, .inSeqB, .inNumBits, .inBitmap,
        .inLastFrag, .inCount, .inSlot, .timedOut(stuck));

    ghbi_interp u_ghbi_interp (.sys_clk, .rst_n, .inValid, .inReady, .inKind, .inFlags,
        .inLength, .inReaderId, .inWriterId, .inSeqA, .inSeqB, .inNumBits, .inBitmap,
        .inLastFrag, .inCount, .inSlot, .inMissing, .srcPrefix, .dstPrefix, .evtDone,
        .evtError, .evtDup, .evtKind, .writerGuid, .readerGuid, .allReaders, .gapFirst,
        .gapLast, .gapRangeValid, .gapBase, .gapBitmap, .hbFirst, .hbLast, .ackNackReq,
        .leaseRenew, .fragSn, .fragLow, .fragHigh);

    // single compare for every kind of value, widened to 128 bits
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // send one submessage, look at the pulses {done,error,dup,acknack,lease}
    task automatic run(input logic [7:0] k, input logic [7:0] f, input logic [15:0] len,
        input logic [31:0] rid, input logic [31:0] wid, input logic [63:0] a,
        input logic [63:0] b, input logic [31:0] x, input logic [4:0] expP);
        u_ghbi_writer_model.send(k, f, len, rid, wid, a, b, nBits, x, resend);
        // send returns at the take edge; the pulses stand for one cycle after the next edge
        @(posedge sys_clk);
        #1;
        if (stuck !== 1'b0) begin
            miscompares++;
            wrap_up();
        end else begin
            // a refused submessage must leave the reported kind as it was
            if (expP[4]) expKind = k;
            chk("pulses", expP, {evtDone, evtError, evtDup, ackNackReq, leaseRenew});
            chk("evtKind", expKind, evtKind);
        end
    endtask

    // range plus bitmap, guids from both prefixes
    task automatic t_gap();
        run(KIND_GAP, 8'h00, 16'h0020, 32'hC7, 32'h102, 64'h5, 64'h9, 32'hFFFFFFF5, 5'h10);
        chk("gapFirst", 128'h5, gapFirst);
        chk("gapLast", 128'h8, gapLast);
        chk("gapRangeValid", 128'h1, gapRangeValid);
        chk("gapBase", 128'h9, gapBase);
        chk("gapBitmap", 128'h5, gapBitmap);
        chk("writerGuid", {srcPrefix, 32'h0000_0102}, writerGuid);
        chk("readerGuid", {dstPrefix, 32'h0000_00C7}, readerGuid);
        chk("allReaders", 128'h0, allReaders);
        // base equal to start: still valid, but the contiguous range is empty
        run(KIND_GAP, 8'h00, 16'h0020, 32'hC7, 32'h102, 64'h5, 64'h5, 32'hFFFFFFF5, 5'h10);
        chk("gapRangeValid", 128'h0, gapRangeValid);
        chk("gapLast", 128'h4, gapLast);
        $display("test gap finished");
    endtask

    // zero, negative, short and unknown kind all refused with no effect
    task automatic t_gap_bad();
        run(KIND_GAP, 8'h00, 16'h0020, 32'h1, 32'h105, 64'h0, 64'hC, 32'h1, 5'h08);
        run(KIND_GAP, 8'h00, 16'h0020, 32'h1, 32'h105, NEG, 64'hC, 32'h1, 5'h08);
        run(KIND_GAP, 8'h00, 16'h001F, 32'h1, 32'h105, 64'h6, 64'hC, 32'h1, 5'h08);
        run(8'h15, 8'h00, 16'h0020, 32'h1, 32'h105, 64'h6, 64'hC, 32'h1, 5'h08);
        chk("gapFirst", 128'h5, gapFirst);
        chk("gapBitmap", 128'h5, gapBitmap);
        chk("writerGuid", {srcPrefix, 32'h0000_0102}, writerGuid);
        $display("test gap refusals finished");
    endtask

    // reply and lease decisions, wildcard reader, duplicate count
    task automatic t_hb();
        run(KIND_HEARTBEAT, 8'h04, 16'h001C, 32'h0, 32'h203, 64'h3, 64'hA, 32'h0, 5'h13);
        chk("hbFirst", 128'h3, hbFirst);
        chk("hbLast", 128'hA, hbLast);
        chk("writerGuid", {srcPrefix, 32'h0000_0203}, writerGuid);
        chk("readerGuid", {dstPrefix, 32'h0000_0000}, readerGuid);
        chk("allReaders", 128'h1, allReaders);
        run(KIND_HEARTBEAT, 8'h02, 16'h001C, 32'h9, 32'h203, 64'h4, 64'h4, 32'h0, 5'h10);
        chk("allReaders", 128'h0, allReaders);
        @(posedge sys_clk);
        inMissing <= 1'b1;
        run(KIND_HEARTBEAT, 8'h06, 16'h001C, 32'h9, 32'h203, 64'h4, 64'h4, 32'h0, 5'h13);
        @(posedge sys_clk);
        inMissing <= 1'b0;
        resend = 1'b1;
        run(KIND_HEARTBEAT, 8'h04, 16'h001C, 32'h9, 32'h203, 64'h1, 64'h8, 32'h0, 5'h14);
        resend = 1'b0;
        chk("hbFirst", 128'h4, hbFirst);
        $display("test heartbeat finished");
    endtask

    // bad sequence numbers and short length refused
    task automatic t_hb_bad();
        run(KIND_HEARTBEAT, 8'h04, 16'h001C, 32'h9, 32'h203, 64'h0, 64'h8, 32'h0, 5'h08);
        run(KIND_HEARTBEAT, 8'h04, 16'h001C, 32'h9, 32'h203, 64'h2, 64'h0, 32'h0, 5'h08);
        run(KIND_HEARTBEAT, 8'h04, 16'h001C, 32'h9, 32'h203, 64'h5, 64'h4, 32'h0, 5'h08);
        run(KIND_HEARTBEAT, 8'h04, 16'h001B, 32'h9, 32'h203, 64'h2, 64'h8, 32'h0, 5'h08);
        chk("hbFirst", 128'h4, hbFirst);
        chk("hbLast", 128'h4, hbLast);
        $display("test heartbeat refusals finished");
    endtask

    // fragment range one to last, then refusals
    task automatic t_frag();
        run(KIND_HB_FRAG, 8'h00, 16'h0018, 32'h5, 32'h304, 64'h7, 64'h0, 32'h3, 5'h10);
        chk("fragSn", 128'h7, fragSn);
        chk("fragLow", 128'h1, fragLow);
        chk("fragHigh", 128'h3, fragHigh);
        chk("readerGuid", {dstPrefix, 32'h0000_0005}, readerGuid);
        // same count again over a second path: reported as duplicate, no fragment field update
        resend = 1'b1;
        run(KIND_HB_FRAG, 8'h00, 16'h0018, 32'h5, 32'h304, 64'h9, 64'h0, 32'h6, 5'h14);
        resend = 1'b0;
        chk("fragSn", 128'h7, fragSn);
        run(KIND_HB_FRAG, 8'h00, 16'h0018, 32'h5, 32'h304, 64'h7, 64'h0, 32'h0, 5'h08);
        run(KIND_HB_FRAG, 8'h00, 16'h0018, 32'h5, 32'h304, NEG, 64'h0, 32'h4, 5'h08);
        run(KIND_HB_FRAG, 8'h00, 16'h0017, 32'h5, 32'h304, 64'h8, 64'h0, 32'h4, 5'h08);
        chk("fragHigh", 128'h3, fragHigh);
        $display("test frag heartbeat finished");
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_gap();
        t_gap_bad();
        t_hb();
        t_hb_bad();
        t_frag();
        wrap_up();
    end
endmodule
`default_nettype wire
